// ### logic/adcg_cv_if.sv
// per-converter link between the control core, trigger detector and scanner
`timescale 1ns/10ps
`default_nettype none
interface adcg_cv_if;
   logic [2:0] start;
   logic       edge_fall;
   logic [5:0] src;
   logic       fire;
   logic [7:0] mask;
   logic [2:0] cur;
   logic       first;
   logic [2:0] nxt;

   modport ctl_mp  (output start, edge_fall, src, mask, cur, first, input fire, nxt);
   modport trig_mp (input start, edge_fall, src, output fire);
   modport scan_mp (input mask, cur, first, output nxt);
endinterface
`default_nettype wire

// ### logic/adcg_pkg.sv
// types shared by the converter-pair control logic
package adcg_pkg;

   typedef enum logic [0:0] {
      ADCG_IDLE = 1'b0,
      ADCG_CONV = 1'b1
   } adcg_cvst_t;

   typedef enum logic [2:0] {
      ADCG_ST_NONE  = 3'h0,
      ADCG_ST_NOW   = 3'h1,
      ADCG_ST_PINA  = 3'h2,
      ADCG_ST_PINB  = 3'h3,
      ADCG_ST_T0M1  = 3'h4,
      ADCG_ST_T0M3  = 3'h5,
      ADCG_ST_T1M0  = 3'h6,
      ADCG_ST_T1M1  = 3'h7
   } adcg_start_t;

endpackage

// ### logic/adcg_regs.svh
// register map, field positions and timing constants of the converter pair
//
// Contract
// - finished conversion presents 10-bit fraction result
// - result carries binary number of converted channel
// - burst sets lost flag on unread overwrite
// - result read clears lost flag
// - completion flag set when conversion finishes
// - result read or control write clears flag
// - control write mid-conversion sets flag, restarts
// - global start write reaches both converters together
// - burst repeats conversions over enabled channels
// - burst scans lowest enabled channel upward
// - clearing burst finishes current conversion first (code: the control write that clears burst restarts a running conversion)
// - burst with non-zero start never converts (code: a control write during a conversion still restarts it)
// - non-burst starts by software/trigger, 11 clocks
// - start code: none, now, or edge
// - codes two to seven pick trigger sources
// - edge bit picks falling or rising trigger
// - operational bit runs converter, resets to zero
// - interrupt request follows completion flag
// - edge detector sees trigger xor edge bit
`ifndef ADCG_REGS_SVH
`define ADCG_REGS_SVH

// ----------------------------------------------------------------
// byte addresses
// ----------------------------------------------------------------
`define ADCG_CTL0_ADDR   32'hE0034000
`define ADCG_RES0_ADDR   32'hE0034004
`define ADCG_GSR_ADDR    32'hE0034008
`define ADCG_CTL1_ADDR   32'hE0060000
`define ADCG_RES1_ADDR   32'hE0060004

// ----------------------------------------------------------------
// control word fields
// ----------------------------------------------------------------
`define ADCG_CTL_WMASK   32'h0F2FFFFF
`define ADCG_GSR_WMASK   32'h0F010000
`define ADCG_CTL_RESET   32'h00000000
`define ADCG_SEL_MSB     7
`define ADCG_SEL_LSB     0
`define ADCG_BURST_BIT   16
`define ADCG_CONVERSION_CLOCK_COUNT_MSB    19
`define ADCG_CONVERSION_CLOCK_COUNT_LSB    17
`define ADCG_OPER_BIT    21
`define ADCG_START_MSB   26
`define ADCG_START_LSB   24
`define ADCG_EDGE_BIT    27

// ----------------------------------------------------------------
// result word fields
// ----------------------------------------------------------------
`define ADCG_RES_PAD_W   6
`define ADCG_CHN_PAD_W   8
`define ADCG_FLG_PAD_W   3
`define ADCG_DONE_BIT    31
`define ADCG_LOST_BIT    30
`define ADCG_RES_FULL    10'h3FF
`define ADCG_RES_ZERO    10'h000

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define ADCG_CONV_LEN    4'hB
`define ADCG_CNT_ONE     4'h1
`define ADCG_CNT_ZERO    4'h0
`define ADCG_TRIG_BASE   3'h2

`endif

// ### logic/adcg_scan.sv
// burst channel scanner: picks the next enabled channel
`timescale 1ns/10ps
`default_nettype none
module adcg_scan
   import adcg_pkg::*;
(
   adcg_cv_if.scan_mp cv
);
   logic [2:0] lowest;
   logic [2:0] above;
   logic       found;

   always_comb begin
      lowest = 3'h0;
      above  = 3'h0;
      found  = 1'b0;
      for (int i = 7; i >= 0; i--) begin
         if (cv.mask[i]) begin
            lowest = 3'(i);
         end
         if (cv.mask[i] && (i > int'(cv.cur))) begin
            above = 3'(i);
            found = 1'b1;
         end
      end
   end

   // wraps to the lowest channel after the highest enabled one
   assign cv.nxt = (cv.first || !found) ? lowest : above;
endmodule
`default_nettype wire

// ### logic/adcg_top.sv
// control and result logic of two converters with a shared global start
//
// Local design decision: the APB register port.
`timescale 1ns/10ps
`default_nettype none
`include "adcg_regs.svh"
module adcg_top
   import adcg_pkg::*;
#(
   parameter int RES_W = 10
)
(
   input  wire logic        sys_clk,
   input  wire logic        nrst,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [31:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic [9:0]  ana_data0,
   input  wire logic [9:0]  ana_data1,
   input  wire logic        timer0_capture_ch2,
   input  wire logic        timer0_capture_ch0,
   input  wire logic        timer0_match_ch1,
   input  wire logic        timer0_match_ch3,
   input  wire logic        timer1_match_ch0,
   input  wire logic        timer1_match_ch1,
   output logic [2:0]       ana_chan0,
   output logic [2:0]       ana_chan1,
   output logic             ana_busy0,
   output logic             ana_busy1,
   output logic             converter_operational0,
   output logic             converter_operational1,
   output logic             irq0,
   output logic             irq1
);

   // ----------------------------------------------------------------
   // elaboration checks
   // ----------------------------------------------------------------
   generate
      if (RES_W != 10) begin : g_bad_width
         $error("adcg_top: result width must be 10");
      end
   endgenerate

   // ----------------------------------------------------------------
   // bus decode
   // ----------------------------------------------------------------
   logic        pready_reg;
   logic        pslverr_reg;
   logic [31:0] prdata_reg;
   logic        pend;
   logic        acc;
   logic        sel_gsr;
   logic [1:0]  sel_ctl;
   logic [1:0]  sel_res;
   logic        hit;
   logic [31:0] rd_word;
   logic [31:0] ctl_rd   [2];
   logic [31:0] res_rd   [2];
   logic [9:0]  ana_in   [2];
   logic [5:0]  trig_src;

   // zero-wait setup then one wait cycle: pready is always registered
   assign pend       = psel & penable & ~pready_reg;
   assign acc        = psel & penable & pready_reg;
   assign sel_ctl[0] = (paddr == `ADCG_CTL0_ADDR);
   assign sel_ctl[1] = (paddr == `ADCG_CTL1_ADDR);
   assign sel_res[0] = (paddr == `ADCG_RES0_ADDR);
   assign sel_res[1] = (paddr == `ADCG_RES1_ADDR);
   assign sel_gsr    = (paddr == `ADCG_GSR_ADDR);
   assign hit        = (|sel_ctl) | (|sel_res) | sel_gsr;
   assign ana_in[0]  = ana_data0;
   assign ana_in[1]  = ana_data1;
   assign trig_src   = {timer1_match_ch1, timer1_match_ch0, timer0_match_ch3,
                        timer0_match_ch1, timer0_capture_ch0, timer0_capture_ch2};

   // global start is write-only and reads as zero
   assign rd_word = sel_ctl[0] ? ctl_rd[0] :
                    sel_ctl[1] ? ctl_rd[1] :
                    sel_res[0] ? res_rd[0] :
                    sel_res[1] ? res_rd[1] : 32'h00000000;

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         pready_reg  <= 1'b0;
         pslverr_reg <= 1'b0;
         prdata_reg  <= 32'h00000000;
      end else begin
         pready_reg  <= pend;
         pslverr_reg <= pend & ~hit;
         prdata_reg  <= pend ? rd_word : prdata_reg;
      end
   end

   assign pready  = pready_reg;
   assign pslverr = pslverr_reg;
   assign prdata  = prdata_reg;

   // ----------------------------------------------------------------
   // converter state, one copy per converter
   // ----------------------------------------------------------------
   logic [31:0] ctl_reg   [2];
   adcg_cvst_t  st_reg    [2];
   logic [3:0]  cnt_reg   [2];
   logic [3:0]  bits_reg  [2];
   logic [2:0]  chan_reg  [2];
   logic        bconv_reg [2];
   logic        brun_reg  [2];
   logic        done_reg  [2];
   logic        lost_reg  [2];
   logic [9:0]  res_reg   [2];
   logic [2:0]  rch_reg   [2];

   adcg_cv_if cv [2] ();

   generate
      for (genvar g = 0; g < 2; g++) begin : g_conv
         logic        ctl_wr;
         logic        rd_res;
         logic        busy;
         logic        fin;
         logic        restart;
         logic        go;
         logic [31:0] ctl_new;
         logic [31:0] ctl_eff;
         logic        e_burst;
         logic        e_oper;
         logic [2:0]  e_start;
         logic [2:0]  e_conversion_clock_count;
         logic        e_bok;
         logic        e_now;
         logic [3:0]  len;
         logic [9:0]  keep;
         logic        clr_done;
         logic        clr_lost;
         logic        set_lost;

         // a global start write is a control write on both at once
         assign ctl_wr  = acc & pwrite & (sel_ctl[g] | sel_gsr);
         assign rd_res  = acc & ~pwrite & sel_res[g];
         assign ctl_new = sel_gsr ?
                          ((ctl_reg[g] & ~`ADCG_GSR_WMASK) | (pwdata & `ADCG_GSR_WMASK)) :
                          (pwdata & `ADCG_CTL_WMASK);
         assign ctl_eff = ctl_wr ? ctl_new : ctl_reg[g];

         assign e_burst = ctl_eff[`ADCG_BURST_BIT];
         assign e_oper  = ctl_eff[`ADCG_OPER_BIT];
         assign e_start = ctl_eff[`ADCG_START_MSB:`ADCG_START_LSB];
         assign e_conversion_clock_count  = ctl_eff[`ADCG_CONVERSION_CLOCK_COUNT_MSB:`ADCG_CONVERSION_CLOCK_COUNT_LSB];
         // non-zero start under burst blocks every conversion except the restart on a control write mid-conversion
         assign e_bok   = e_burst & (e_start == ADCG_ST_NONE);
         assign e_now   = ~e_burst & (e_start == ADCG_ST_NOW);

         // burst uses the clock count, single conversions are full length
         assign len = e_burst ? (`ADCG_CONV_LEN - {1'b0, e_conversion_clock_count})
                              : `ADCG_CONV_LEN;

         assign busy    = (st_reg[g] == ADCG_CONV);
         assign restart = ctl_wr & busy;
         assign fin     = busy & ~ctl_wr & (cnt_reg[g] == `ADCG_CNT_ZERO);

         // starts only from idle, apart from the restart on a control write
         assign go = ctl_wr ? (e_oper & (busy | e_now | e_bok))
                            : (~busy & e_oper &
                               (e_bok | (~e_burst & cv[g].fire)));

         assign cv[g].start     = ctl_reg[g][`ADCG_START_MSB:`ADCG_START_LSB];
         assign cv[g].edge_fall = ctl_reg[g][`ADCG_EDGE_BIT];
         assign cv[g].src       = trig_src;
         assign cv[g].mask      = ctl_eff[`ADCG_SEL_MSB:`ADCG_SEL_LSB];
         assign cv[g].cur       = chan_reg[g];
         assign cv[g].first     = ~brun_reg[g] | ctl_wr;

         adcg_trig u_trig (
            .sys_clk (sys_clk),
            .nrst    (nrst),
            .cv      (cv[g].trig_mp)
         );

         adcg_scan u_scan (
            .cv (cv[g].scan_mp)
         );

         // shorter conversions leave the low result bits at zero
         assign keep = ~(`ADCG_RES_FULL >> bits_reg[g]);

         // read clears only what the captured word showed
         assign clr_done = ctl_wr | (rd_res & prdata_reg[`ADCG_DONE_BIT]);
         assign clr_lost = rd_res & prdata_reg[`ADCG_LOST_BIT];
         assign set_lost = fin & bconv_reg[g] & done_reg[g] & ~clr_done;

         always_ff @(posedge sys_clk or negedge nrst) begin
            if (!nrst) begin
               ctl_reg[g]   <= `ADCG_CTL_RESET;
               st_reg[g]    <= ADCG_IDLE;
               cnt_reg[g]   <= `ADCG_CNT_ZERO;
               bits_reg[g]  <= `ADCG_CNT_ZERO;
               chan_reg[g]  <= 3'h0;
               bconv_reg[g] <= 1'b0;
               brun_reg[g]  <= 1'b0;
            end else begin
               ctl_reg[g] <= ctl_eff;
               if (go) begin
                  st_reg[g]    <= ADCG_CONV;
                  cnt_reg[g]   <= len - `ADCG_CNT_ONE;
                  bits_reg[g]  <= len - `ADCG_CNT_ONE;
                  chan_reg[g]  <= cv[g].nxt;
                  bconv_reg[g] <= e_burst;
               end else if (fin) begin
                  st_reg[g] <= ADCG_IDLE;
               end else if (busy) begin
                  cnt_reg[g] <= cnt_reg[g] - `ADCG_CNT_ONE;
               end
               // scan position restarts once burst is dropped
               brun_reg[g] <= (go & e_burst) | (brun_reg[g] & e_burst);
            end
         end

         always_ff @(posedge sys_clk or negedge nrst) begin
            if (!nrst) begin
               done_reg[g] <= 1'b0;
               lost_reg[g] <= 1'b0;
               res_reg[g]  <= `ADCG_RES_ZERO;
               rch_reg[g]  <= 3'h0;
            end else begin
               // a finishing conversion wins over a clear in the same cycle
               done_reg[g] <= fin | restart | (done_reg[g] & ~clr_done);
               if (fin) begin
                  lost_reg[g] <= set_lost | (lost_reg[g] & ~clr_lost);
                  res_reg[g]  <= ana_in[g] & keep;
                  rch_reg[g]  <= chan_reg[g];
               end else begin
                  lost_reg[g] <= lost_reg[g] & ~clr_lost;
               end
            end
         end

         // writes to the result word land nowhere
         assign res_rd[g] = {done_reg[g], lost_reg[g], {`ADCG_FLG_PAD_W{1'b0}},
                             rch_reg[g], {`ADCG_CHN_PAD_W{1'b0}}, res_reg[g],
                             {`ADCG_RES_PAD_W{1'b0}}};
         assign ctl_rd[g] = ctl_reg[g] & `ADCG_CTL_WMASK;
      end
   endgenerate

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign ana_chan0              = chan_reg[0];
   assign ana_chan1              = chan_reg[1];
   assign ana_busy0              = (st_reg[0] == ADCG_CONV);
   assign ana_busy1              = (st_reg[1] == ADCG_CONV);
   assign converter_operational0 = ctl_reg[0][`ADCG_OPER_BIT];
   assign converter_operational1 = ctl_reg[1][`ADCG_OPER_BIT];
   assign irq0                   = done_reg[0];
   assign irq1                   = done_reg[1];

endmodule
`default_nettype wire

// ### logic/adcg_trig.sv
// hardware start trigger: source select and edge detection
`timescale 1ns/10ps
`default_nettype none
`include "adcg_regs.svh"
module adcg_trig
   import adcg_pkg::*;
(
   input wire logic   sys_clk,
   input wire logic   nrst,
   adcg_cv_if.trig_mp cv
);
   logic [2:0] idx;
   logic [7:0] src_ext;
   logic       use_src;
   logic       sig;
   logic       prev_reg;

   assign use_src = (cv.start >= `ADCG_TRIG_BASE);
   assign idx     = cv.start - `ADCG_TRIG_BASE;
   // codes below two wrap the index past the sources: pad and gate so no unknown
   // reaches the edge history
   assign src_ext = {2'b00, cv.src};
   // one rising detector serves both polarities
   assign sig     = (use_src & src_ext[idx]) ^ cv.edge_fall;
   assign cv.fire = use_src & sig & ~prev_reg;

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         prev_reg <= 1'b0;
      end else begin
         prev_reg <= sig;
      end
   end
endmodule
`default_nettype wire

// ### testbench/adcg_chk.sv
// concurrent checks on the ports of the converter pair
`timescale 1ns/10ps
`default_nettype none
`include "adcg_regs.svh"
module adcg_chk (
   input wire logic        sys_clk,
   input wire logic        nrst,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        ana_busy0,
   input wire logic        ana_busy1,
   input wire logic        converter_operational0,
   input wire logic        converter_operational1,
   input wire logic        irq0
);
   logic [4:0] len_cnt;
   wire        mapped;
   wire        wr_done;
   wire        rd_res0;
   wire        wr_ctl0;
   assign mapped = paddr inside {`ADCG_CTL0_ADDR, `ADCG_RES0_ADDR, `ADCG_GSR_ADDR,
                                 `ADCG_CTL1_ADDR, `ADCG_RES1_ADDR};
   assign wr_done = pready && pwrite && !pslverr;
   assign rd_res0 = pready && !pwrite && paddr == `ADCG_RES0_ADDR;
   assign wr_ctl0 = wr_done && (paddr == `ADCG_CTL0_ADDR || paddr == `ADCG_GSR_ADDR);
   // ----
   // busy length, zeroed by control writes since those may restart a conversion
   // ----
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         len_cnt <= 5'h00;
      end else if (!ana_busy0 || wr_ctl0) begin
         len_cnt <= 5'h00;
      end else begin
         len_cnt <= len_cnt + 5'h01;
      end
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!nrst);
   a_pready_pulse: assert property (pready |-> psel && penable && $past(penable) ##1 !pready)
      else $error("pready outside a single access cycle");
   a_slverr_map: assert property (pready |-> pslverr == !mapped)
      else $error("slave error does not follow the address map");
   a_unmapped_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
      else $error("unmapped read returned data");
   a_res_pad: assert property (rd_res0 |-> prdata[5:0] == 6'h0 && prdata[29:27] == 3'h0
      && prdata[23:16] == 8'h0)
      else $error("result padding bits not zero");
   a_irq_finish: assert property ($fell(ana_busy0) |-> irq0)
      else $error("no request at conversion end");
   a_read_clear: assert property (rd_res0 && prdata[31] |=> !irq0 || $fell(ana_busy0))
      else $error("result read left the request up");
   a_ctl_clear: assert property (wr_done && paddr == `ADCG_CTL0_ADDR && !ana_busy0
      |=> !irq0)
      else $error("control write left the request up");
   a_ctl_busy: assert property (wr_done && paddr == `ADCG_CTL0_ADDR && ana_busy0 |=> irq0)
      else $error("write during conversion did not flag completion");
   a_busy_oper: assert property ($rose(ana_busy0) |-> converter_operational0)
      else $error("conversion while powered down");
   a_oper_write: assert property ($changed(converter_operational0) |-> $past(wr_done))
      else $error("operational bit moved without a write");
   a_conv_len: assert property ($fell(ana_busy0) |-> len_cnt inside {[1:11]})
      else $error("conversion longer than eleven cycles");
   a_gsr_both: assert property (wr_done && paddr == `ADCG_GSR_ADDR
      && pwdata[26:24] == 3'h1 && !pwdata[16] && converter_operational0 && converter_operational1
      |-> ##2 ana_busy0 && ana_busy1)
      else $error("global start did not reach both converters");
endmodule
bind adcg_top adcg_chk adcg_chk_inst (.sys_clk(sys_clk), .nrst(nrst), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .ana_busy0(ana_busy0), .ana_busy1(ana_busy1),
   .converter_operational0(converter_operational0),
   .converter_operational1(converter_operational1), .irq0(irq0));
`default_nettype wire

// ### testbench/adcg_partner.sv
// trigger lines and analog result source beside the converter pair
`timescale 1ns/10ps
`default_nettype none
module adcg_partner (
   input  wire logic       sys_clk,
   input  wire logic       nrst,
   input  wire logic [5:0] trig_lvl,
   input  wire logic [9:0] ana_base,
   input  wire logic       ana_busy0,
   input  wire logic       ana_busy1,
   output logic      [5:0] trig_out,
   output logic      [9:0] ana_data0,
   output logic      [9:0] ana_data1
);
   // timer and pin levels arrive synchronous to the bus clock
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         trig_out <= 6'h00;
      end else begin
         trig_out <= trig_lvl;
      end
   end
   // the core output is not held: converter 0 sees the inverse outside a conversion, converter 1 during one
   assign ana_data0 = ana_busy0 ? ana_base : ~ana_base;
   assign ana_data1 = ana_busy1 ? ~ana_base : ana_base;
endmodule
`default_nettype wire

// ### testbench/testbench.sv
// self-checking bench for the converter pair control logic
`timescale 1ns/10ps
`default_nettype none
`include "adcg_regs.svh"
module testbench;
   logic        sys_clk, nrst, psel, penable, pwrite, pready, pslverr;
   logic [31:0] paddr, pwdata, prdata, q;
   logic [9:0]  ana_data0, ana_data1, base;
   logic [7:0]  m;
   logic [5:0]  trig_lvl, trig;
   logic [2:0]  ana_chan0, ana_chan1, ch, k;
   logic        ana_busy0, ana_busy1, op0, op1, irq0, irq1, err, seen, both;
   int          error_cnt, samples_checked, cyc, len;

   adcg_top adcg_top_inst (.sys_clk(sys_clk), .nrst(nrst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .ana_data0(ana_data0), .ana_data1(ana_data1),
      .timer0_capture_ch2(trig[0]), .timer0_capture_ch0(trig[1]), .timer0_match_ch1(trig[2]),
      .timer0_match_ch3(trig[3]), .timer1_match_ch0(trig[4]), .timer1_match_ch1(trig[5]),
      .ana_chan0(ana_chan0), .ana_chan1(ana_chan1), .ana_busy0(ana_busy0),
      .ana_busy1(ana_busy1), .converter_operational0(op0), .converter_operational1(op1),
      .irq0(irq0), .irq1(irq1));
   adcg_partner adcg_partner_inst (.sys_clk(sys_clk), .nrst(nrst), .trig_lvl(trig_lvl),
      .ana_base(base), .ana_busy0(ana_busy0), .ana_busy1(ana_busy1), .trig_out(trig),
      .ana_data0(ana_data0), .ana_data1(ana_data1));

   // ----
   // helpers
   // ----
   function automatic logic [31:0] ctl(input logic [7:0] mk, input logic b,
                                       input logic [2:0] kk, s, input logic e);
      return {4'h0, e, s, 3'h1, 1'b0, kk, b, 8'h00, mk};
   endfunction
   function automatic logic [2:0] lowbit(input logic [7:0] mk);
      lowbit = 3'h0;
      for (int i = 7; i >= 0; i--) begin
         if (mk[i]) lowbit = i[2:0];
      end
   endfunction
   function automatic logic [31:0] resw(input logic [9:0] d, input logic [2:0] c, kk,
                                        input logic lost);
      return {1'b1, lost, 3'h0, c, 8'h00, d & (10'h3FF << kk), 6'h00};
   endfunction
   task automatic chk(input string nm, input logic [31:0] seen_v, exp_v);
      samples_checked++;
      if (seen_v !== exp_v) begin
         error_cnt++;
         $display("unexpected %s: expected %h seen %h", nm, exp_v, seen_v);
      end
   endtask
   // one spare edge after release, so a following call never re-drives in the same step
   task automatic apb(input logic wr, input logic [31:0] a, d);
      int n;
      n = 0;
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      do begin
         @(posedge sys_clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      q = prdata;
      err = pslverr;
      if (n >= 20) chk("pready", 0, 1);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge sys_clk);
   endtask
   task automatic conv0();
      int n;
      n = 0;
      while (ana_busy0 !== 1'b1 && n < 100) begin
         @(posedge sys_clk);
         n++;
      end
      ch = ana_chan0;
      both = ana_busy1;
      len = 0;
      while (ana_busy0 === 1'b1 && len < 40) begin
         len++;
         @(posedge sys_clk);
      end
   endtask
   task automatic quiet(input int n);
      seen = 1'b0;
      repeat (n) begin
         @(posedge sys_clk);
         if (ana_busy0 !== 1'b0) seen = 1'b1;
      end
   endtask
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
      if (error_cnt == 0 && samples_checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   initial begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (cyc == 6000) begin
         error_cnt++;
         give_verdict();
      end
   end

   // ----
   // tests
   // ----
   initial begin
      {nrst, psel, penable, pwrite, paddr, pwdata} = '0;
      {trig_lvl, base, error_cnt, samples_checked, cyc} = '0;
      q = $urandom(32'h1A1E);
      repeat (6) @(posedge sys_clk);
      nrst <= 1'b1;
      @(posedge sys_clk);
      apb(0, `ADCG_CTL0_ADDR, 0);
      chk("ctl0", q, 0);
      chk("oper0", op0, 0);
      apb(1, `ADCG_RES0_ADDR, 32'hFFFFFFFF);
      apb(0, `ADCG_RES0_ADDR, 0);
      chk("res0", q, 0);
      apb(0, 32'hE0034010, 0);
      chk("slverr", err, 1);
      chk("unmapped", q, 0);
      $display("test reset done");
      for (int i = 0; i < 6; i++) begin
         m = 8'($urandom_range(255, 1));
         base <= (i == 0) ? 10'h000 : (i == 1) ? 10'h3FF : 10'($urandom);
         apb(1, `ADCG_CTL0_ADDR, ctl(m, 0, 0, 1, 0));
         conv0();
         chk("len", len, 11);
         chk("chan", ch, lowbit(m));
         chk("irq0", irq0, 1);
         apb(0, `ADCG_RES0_ADDR, 0);
         chk("result", q, resw(base, lowbit(m), 0, 0));
         chk("irq0_clr", irq0, 0);
      end
      apb(1, `ADCG_CTL0_ADDR, ctl(m, 0, 0, 1, 0));
      repeat (3) @(posedge sys_clk);
      apb(1, `ADCG_CTL0_ADDR, ctl(m, 0, 0, 1, 0));
      chk("mid_write", irq0, 1);
      conv0();
      $display("test software start done");
      apb(1, `ADCG_CTL1_ADDR, ctl(8'h80, 0, 0, 0, 0));
      chk("oper1", op1, 1);
      apb(1, `ADCG_GSR_ADDR, 32'h01000000);
      conv0();
      chk("both_start", both, 1);
      chk("gsr_len", len, 11);
      chk("chan1", ana_chan1, 3'h7);
      chk("irq1", irq1, 1);
      apb(0, `ADCG_RES1_ADDR, 0);
      chk("result1", q, resw(~base, 3'h7, 0, 0));
      chk("irq1_clr", irq1, 0);
      $display("test global start done");
      for (int c = 2; c < 8; c++) begin
         for (int e = 0; e < 2; e++) begin
            trig_lvl <= {6{e[0]}};
            repeat (3) @(posedge sys_clk);
            apb(1, `ADCG_CTL0_ADDR, ctl(8'h01, 0, 0, c[2:0], e[0]));
            trig_lvl <= {6{!e[0]}} ^ (6'h01 << (c - 2));
            quiet(5);
            chk("other_src", seen, 0);
            trig_lvl[c - 2] <= !e[0];
            conv0();
            chk("trig_len", len, 11);
            apb(1, `ADCG_CTL0_ADDR, ctl(8'h01, 0, 0, 0, 0));
         end
      end
      trig_lvl <= ~trig_lvl;
      quiet(8);
      chk("no_start", seen, 0);
      $display("test triggers done");
      k = 3'($urandom_range(5, 0));
      apb(1, `ADCG_CTL0_ADDR, ctl(8'hA4, 1, k, 0, 0));
      for (int i = 0; i < 4; i++) begin
         conv0();
         chk("burst_chan", ch, i == 1 ? 5 : i == 2 ? 7 : 2);
         chk("burst_len", len, 11 - k);
      end
      apb(0, `ADCG_RES0_ADDR, 0);
      chk("lost", q, resw(base, 3'h2, k, 1));
      apb(1, `ADCG_CTL0_ADDR, ctl(8'hA4, 0, k, 0, 0));
      repeat (14) @(posedge sys_clk);
      quiet(20);
      chk("burst_stop", seen, 0);
      apb(0, `ADCG_RES0_ADDR, 0);
      apb(0, `ADCG_RES0_ADDR, 0);
      chk("flags_clr", q[31:30], 0);
      $display("test burst done");
      apb(1, `ADCG_CTL0_ADDR, ctl(8'h01, 1, 0, 1, 0));
      quiet(30);
      chk("burst_start", seen, 0);
      apb(1, `ADCG_CTL0_ADDR, ctl(8'h01, 0, 0, 0, 0) & 32'hFFDFFFFF);
      chk("oper_off", op0, 0);
      apb(1, `ADCG_CTL0_ADDR, ctl(8'h01, 0, 0, 1, 0) & 32'hFFDFFFFF);
      quiet(20);
      chk("pdn_start", seen, 0);
      $display("test power down done");
      give_verdict();
   end
endmodule
`default_nettype wire
